// >>> stepper_cfg_pkg.sv
`default_nettype none
package stepper_cfg_pkg;
    localparam int CLK_MHZ = 125;
    localparam int STOP_TIME_NS = 1000;
    localparam int STOP_CYCLES = (STOP_TIME_NS * CLK_MHZ) / 1000;
    localparam int STOP_CNT_W = 8;

    localparam logic [6:0] ADDR_GLOBAL_CONFIG = 7'h00;
    localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
    localparam logic [6:0] ADDR_CURRENT_ONE = 7'h30;
    localparam logic [6:0] ADDR_CURRENT_TWO = 7'h50;
    localparam logic [6:0] ADDR_CHOPPER_ONE = 7'h6C;
    localparam logic [6:0] ADDR_CHOPPER_TWO = 7'h7C;

    localparam logic [31:0] GLOBAL_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CHOPPER_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CURRENT_RESET = 32'h0000_0000;
    localparam logic [31:0] GLOBAL_STATUS_RESET = 32'h0000_0001;

    localparam int STEPDIR_ONE_BIT = 1;
    localparam int STEPDIR_TWO_BIT = 2;
    localparam int OFF_TIME_LSB = 0;
    localparam int OFF_TIME_W = 4;

    localparam logic [7:0] UART_SYNC = 8'h05;
    localparam logic [7:0] UART_MASTER_ADDR = 8'hFF;
    localparam logic [7:0] SLAVE_ADDR_LOW = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_HIGH = 8'h01;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam int UART_WRITE_BIT = 7;
    localparam logic [2:0] DATA_BYTES_LAST = 3'h3;
    localparam logic [2:0] REPLY_CRC_IDX = 3'h7;

    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [31:0] data;
    } spi_dgram_type;

    typedef enum logic [2:0] {
        U_SYNC, U_SLAVE, U_REG, U_DATA, U_CRC, U_REPLY
    } uart_state_type;
endpackage
`default_nettype wire

// >>> clock_source_select.sv
`timescale 1ns/10ps
`default_nettype none
module clock_source_select import stepper_cfg_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clk_pin,
    output logic ext_sel,
    output logic clk_stopped
);
    logic pin_prev;
    logic [STOP_CNT_W-1:0] idle_cnt;
    wire pin_edge = clk_pin != pin_prev;
    wire idle_full = idle_cnt == STOP_CNT_W'(STOP_CYCLES);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_sel <= 1'b0;
            pin_prev <= 1'b0;
            idle_cnt <= '0;
            clk_stopped <= 1'b0;
        end else if (ce) begin
            pin_prev <= clk_pin;
            // First high level switches to the external source for good
            if (clk_pin) begin
                ext_sel <= 1'b1;
            end
            if (pin_edge || !ext_sel) begin
                idle_cnt <= '0;
            end else if (!idle_full) begin
                idle_cnt <= idle_cnt + STOP_CNT_W'(1);
            end
            clk_stopped <= ext_sel && idle_full;
        end
    end

    AST_STOP_FLAG: assert property (@(posedge clk) disable iff (!resetn)
        ce && ext_sel && idle_full |=> clk_stopped)
        else $error("Stopped external clock not flagged");
endmodule
`default_nettype wire

// >>> stepper_cfg_top.sv
// Operation
// - The device answers UART slave address 0 while its address select pin is low.
// - Reset loads every configuration register with its default before any host access.
// - With the clock pin held low the device runs from its internal oscillator.
// - The first high level on the clock pin switches the device to the external clock for good.
// - A stopped external clock halts the chopper while short detection, if enabled, stays active.
`timescale 1ns/10ps
`default_nettype none
module stepper_cfg_top import stepper_cfg_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic SPI_VALID,
    input wire spi_dgram_type SPI_DGRAM,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic TX_READY,
    input wire logic UART_ADDRESS_SELECT_PIN,
    input wire logic CLK_PIN,
    input wire logic SHORT_GUARD_EN,
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    output logic [31:0] GLOBAL_CONFIG_REG,
    output logic [31:0] GLOBAL_STATUS_REG,
    output logic [31:0] CHOPPER_CONFIG_REG_ONE,
    output logic [31:0] CHOPPER_CONFIG_REG_TWO,
    output logic [31:0] CURRENT_REG_ONE,
    output logic [31:0] CURRENT_REG_TWO,
    output logic DRIVER_ONE_STEPDIR_ENABLE,
    output logic DRIVER_TWO_STEPDIR_ENABLE,
    output logic CLK_SOURCE_EXT,
    output logic CHOPPER_ONE_RUN,
    output logic CHOPPER_TWO_RUN,
    output logic SHORT_GUARD_ACTIVE
);
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        logic [7:0] d;
        c = crc;
        d = data;
        for (int i = 0; i < 8; i++) begin
            if (c[7] ^ d[0]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
            d = {1'b0, d[7:1]};
        end
        return c;
    endfunction

    function automatic logic [7:0] reply_byte(input logic [2:0] idx, input logic [6:0] addr,
                                              input logic [31:0] data);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'h0: b = UART_SYNC;
            3'h1: b = UART_MASTER_ADDR;
            3'h2: b = {1'b0, addr};
            3'h3: b = data[31:24];
            3'h4: b = data[23:16];
            3'h5: b = data[15:8];
            3'h6: b = data[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    uart_state_type ustate;
    logic [7:0] crc_acc;
    logic addr_hit;
    logic rx_write;
    logic [6:0] rx_addr;
    logic [31:0] rx_data;
    logic [2:0] byte_cnt;
    logic [2:0] tx_idx;
    logic [7:0] crc_tx;
    logic [31:0] reply_data;
    logic [6:0] reply_addr;
    logic clk_stopped;
    logic ext_sel;

    wire rx_take = CLK_EN && RX_VALID && ustate != U_REPLY;
    wire [7:0] my_slave = UART_ADDRESS_SELECT_PIN ? SLAVE_ADDR_HIGH : SLAVE_ADDR_LOW;
    wire [7:0] next_crc_acc = crc_step(crc_acc, RX_BYTE);
    wire crc_ok = RX_BYTE == crc_acc;
    wire uart_accept = rx_take && ustate == U_CRC && crc_ok && addr_hit;
    wire uart_wr = uart_accept && rx_write;
    wire uart_rd = uart_accept && !rx_write;
    wire spi_wr = CLK_EN && SPI_VALID && SPI_DGRAM.write;

    // SPI has priority when both links write in the same cycle
    wire wr_en = spi_wr || uart_wr;
    wire [6:0] wr_addr = spi_wr ? SPI_DGRAM.addr : rx_addr;
    wire [31:0] wr_data = spi_wr ? SPI_DGRAM.data : rx_data;
    wire wr_global_config_reg = wr_en && wr_addr == ADDR_GLOBAL_CONFIG;
    wire wr_global_status_reg = wr_en && wr_addr == ADDR_GLOBAL_STATUS;
    wire [31:0] next_global_config_reg = wr_global_config_reg ? wr_data : GLOBAL_CONFIG_REG;

    wire [31:0] rd_data =
        rx_addr == ADDR_GLOBAL_CONFIG ? GLOBAL_CONFIG_REG :
        rx_addr == ADDR_GLOBAL_STATUS ? GLOBAL_STATUS_REG :
        rx_addr == ADDR_CHOPPER_ONE ? CHOPPER_CONFIG_REG_ONE :
        rx_addr == ADDR_CHOPPER_TWO ? CHOPPER_CONFIG_REG_TWO :
        rx_addr == ADDR_CURRENT_ONE ? CURRENT_REG_ONE :
        rx_addr == ADDR_CURRENT_TWO ? CURRENT_REG_TWO : 32'h0000_0000;

    wire tx_fire = TX_VALID && TX_READY && CLK_EN;
    wire [7:0] next_crc_tx = crc_step(crc_tx, TX_BYTE);
    wire [2:0] next_tx_idx = tx_idx + 3'h1;
    wire chop_one_on = CHOPPER_CONFIG_REG_ONE[OFF_TIME_LSB +: OFF_TIME_W] != '0;
    wire chop_two_on = CHOPPER_CONFIG_REG_TWO[OFF_TIME_LSB +: OFF_TIME_W] != '0;

    clock_source_select u_clock_source_select (
        .clk(REF_CLK),
        .resetn(RESETN),
        .ce(CLK_EN),
        .clk_pin(CLK_PIN),
        .ext_sel(ext_sel),
        .clk_stopped(clk_stopped)
    );

    always_comb begin
        CLK_SOURCE_EXT = ext_sel;
    end

    // Configuration registers
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            GLOBAL_CONFIG_REG <= GLOBAL_CONFIG_RESET;
            CHOPPER_CONFIG_REG_ONE <= CHOPPER_CONFIG_RESET;
            CHOPPER_CONFIG_REG_TWO <= CHOPPER_CONFIG_RESET;
            CURRENT_REG_ONE <= CURRENT_RESET;
            CURRENT_REG_TWO <= CURRENT_RESET;
            GLOBAL_STATUS_REG <= GLOBAL_STATUS_RESET;
            DRIVER_ONE_STEPDIR_ENABLE <= GLOBAL_CONFIG_RESET[STEPDIR_ONE_BIT];
            DRIVER_TWO_STEPDIR_ENABLE <= GLOBAL_CONFIG_RESET[STEPDIR_TWO_BIT];
        end else if (CLK_EN) begin
            GLOBAL_CONFIG_REG <= next_global_config_reg;
            DRIVER_ONE_STEPDIR_ENABLE <= next_global_config_reg[STEPDIR_ONE_BIT];
            DRIVER_TWO_STEPDIR_ENABLE <= next_global_config_reg[STEPDIR_TWO_BIT];
            if (wr_en && wr_addr == ADDR_CHOPPER_ONE) begin
                CHOPPER_CONFIG_REG_ONE <= wr_data;
            end
            if (wr_en && wr_addr == ADDR_CHOPPER_TWO) begin
                CHOPPER_CONFIG_REG_TWO <= wr_data;
            end
            if (wr_en && wr_addr == ADDR_CURRENT_ONE) begin
                CURRENT_REG_ONE <= wr_data;
            end
            if (wr_en && wr_addr == ADDR_CURRENT_TWO) begin
                CURRENT_REG_TWO <= wr_data;
            end
            // Status bits clear by writing one; none is set again after reset
            if (wr_global_status_reg) begin
                GLOBAL_STATUS_REG <= GLOBAL_STATUS_REG & ~wr_data;
            end
        end
    end

    // Chopper and short guard
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            CHOPPER_ONE_RUN <= 1'b0;
            CHOPPER_TWO_RUN <= 1'b0;
            SHORT_GUARD_ACTIVE <= 1'b0;
        end else if (CLK_EN) begin
            CHOPPER_ONE_RUN <= chop_one_on && !clk_stopped;
            CHOPPER_TWO_RUN <= chop_two_on && !clk_stopped;
            SHORT_GUARD_ACTIVE <= SHORT_GUARD_EN;
        end
    end

    // UART datagram receiver and reply sender
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            ustate <= U_SYNC;
            crc_acc <= CRC_INIT;
            addr_hit <= 1'b0;
            rx_write <= 1'b0;
            rx_addr <= '0;
            rx_data <= '0;
            byte_cnt <= '0;
            tx_idx <= '0;
            crc_tx <= CRC_INIT;
            reply_data <= '0;
            reply_addr <= '0;
            TX_VALID <= 1'b0;
            TX_BYTE <= 8'h00;
        end else if (CLK_EN) begin
            if (rx_take) begin
                crc_acc <= next_crc_acc;
            end
            case (ustate)
                U_SYNC: begin
                    if (rx_take && RX_BYTE == UART_SYNC) begin
                        ustate <= U_SLAVE;
                    end else begin
                        crc_acc <= CRC_INIT;
                    end
                end
                U_SLAVE: begin
                    if (rx_take) begin
                        addr_hit <= RX_BYTE == my_slave;
                        ustate <= U_REG;
                    end
                end
                U_REG: begin
                    if (rx_take) begin
                        rx_write <= RX_BYTE[UART_WRITE_BIT];
                        rx_addr <= RX_BYTE[6:0];
                        byte_cnt <= '0;
                        ustate <= RX_BYTE[UART_WRITE_BIT] ? U_DATA : U_CRC;
                    end
                end
                U_DATA: begin
                    if (rx_take) begin
                        rx_data <= {rx_data[23:0], RX_BYTE};
                        byte_cnt <= byte_cnt + 3'h1;
                        if (byte_cnt == DATA_BYTES_LAST) begin
                            ustate <= U_CRC;
                        end
                    end
                end
                U_CRC: begin
                    if (rx_take) begin
                        crc_acc <= CRC_INIT;
                        if (uart_rd) begin
                            reply_addr <= rx_addr;
                            reply_data <= rd_data;
                            tx_idx <= '0;
                            crc_tx <= CRC_INIT;
                            TX_BYTE <= UART_SYNC;
                            TX_VALID <= 1'b1;
                            ustate <= U_REPLY;
                        end else begin
                            ustate <= U_SYNC;
                        end
                    end
                end
                U_REPLY: begin
                    if (tx_fire) begin
                        crc_tx <= next_crc_tx;
                        tx_idx <= next_tx_idx;
                        if (tx_idx == REPLY_CRC_IDX) begin
                            TX_VALID <= 1'b0;
                            ustate <= U_SYNC;
                        end else if (next_tx_idx == REPLY_CRC_IDX) begin
                            TX_BYTE <= next_crc_tx;
                        end else begin
                            TX_BYTE <= reply_byte(next_tx_idx, reply_addr, reply_data);
                        end
                    end
                end
                default: begin
                    ustate <= U_SYNC;
                end
            endcase
        end
    end

    AST_RESET_DEFAULTS: assert property (@(posedge REF_CLK) !RESETN |=>
        GLOBAL_CONFIG_REG == GLOBAL_CONFIG_RESET && CHOPPER_CONFIG_REG_ONE == CHOPPER_CONFIG_RESET
        && CURRENT_REG_TWO == CURRENT_RESET && !DRIVER_ONE_STEPDIR_ENABLE && !TX_VALID)
        else $error("Defaults not loaded by reset");
    AST_SLAVE_ZERO: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        rx_take && ustate == U_SLAVE && !UART_ADDRESS_SELECT_PIN && RX_BYTE == SLAVE_ADDR_LOW |=> addr_hit)
        else $error("Slave address 0 not matched with select pin low");
    AST_BAD_CRC: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        rx_take && ustate == U_CRC && !crc_ok && !SPI_VALID |=>
        $stable(CHOPPER_CONFIG_REG_ONE) && $stable(CURRENT_REG_ONE) && $stable(GLOBAL_CONFIG_REG) && !TX_VALID)
        else $error("Datagram with bad CRC took effect");
    AST_INT_OSC: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        !CLK_SOURCE_EXT && !CLK_PIN |=> !CLK_SOURCE_EXT)
        else $error("Left internal oscillator without clock pin high");
    AST_EXT_SWITCH: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        CLK_EN && CLK_PIN |=> CLK_SOURCE_EXT [*3])
        else $error("External clock not selected after high level");
    AST_CHOP_HALT: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        CLK_EN && clk_stopped |=> !CHOPPER_ONE_RUN && !CHOPPER_TWO_RUN)
        else $error("Chopper runs without clock");
    AST_SHORT_GUARD: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        CLK_EN && SHORT_GUARD_EN && clk_stopped |=> SHORT_GUARD_ACTIVE)
        else $error("Short guard dropped while clock stopped");
    AST_READ_REPLY: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        uart_rd |=> TX_VALID && TX_BYTE == UART_SYNC && ustate == U_REPLY)
        else $error("Accepted read not answered");
    AST_UART_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        uart_wr && !SPI_VALID && rx_addr == ADDR_CHOPPER_TWO |=> CHOPPER_CONFIG_REG_TWO == $past(rx_data))
        else $error("Accepted UART write not stored");
endmodule
`default_nettype wire

// >>> host_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_link_model import stepper_cfg_pkg::*; (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic spi_valid,
    output spi_dgram_type spi_dgram,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    logic [7:0] reply [0:7];
    initial begin
        spi_valid = 1'b0;
        spi_dgram = '0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // With last low the strobe stays up so the next datagram follows back to back
    task automatic spi_send(input logic [39:0] word, input logic last);
        @(posedge clk);
        #1;
        spi_valid = 1'b1;
        spi_dgram = word;
        if (last) begin
            @(posedge clk);
            #1;
            spi_valid = 1'b0;
            spi_dgram = ~word;
        end
    endtask
    // Sends n bytes and then their check byte, inverted in bit 0 when bad is set
    task automatic send_frame(input logic [7:0] f [0:6], input int n, input logic bad);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i <= n; i++) begin
            if (i < n) c = crc_step(c, f[i]);
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_byte = (i < n) ? f[i] : (c ^ {7'h00, bad});
            @(posedge clk);
            #1;
            rx_valid = 1'b0;
            rx_byte = ~rx_byte;
        end
    endtask
    task automatic uart_write(input logic [7:0] slave, input logic [7:0] reg_byte, input logic [31:0] data,
                              input logic bad);
        send_frame('{UART_SYNC, slave, reg_byte, data[31:24], data[23:16], data[15:8], data[7:0]}, 7, bad);
    endtask
    // Each reply byte is stalled one cycle before it is taken
    task automatic uart_read(input logic [7:0] slave, input logic [7:0] reg_byte);
        int n;
        send_frame('{UART_SYNC, slave, reg_byte, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
        for (int k = 0; k < 8; k++) begin
            n = 0;
            while (tx_valid !== 1'b1 && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
            @(posedge clk);
            #1;
            tx_ready = 1'b1;
            reply[k] = tx_byte;
            @(posedge clk);
            #1;
            tx_ready = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// >>> test_stepper_driver_init_and_clock.sv
`timescale 1ns/10ps
`default_nettype none
module test_stepper_driver_init_and_clock import stepper_cfg_pkg::*;;
    logic REF_CLK, RESETN, CLK_EN, SPI_VALID, RX_VALID, TX_READY, UART_ADDRESS_SELECT_PIN, CLK_PIN, SHORT_GUARD_EN;
    spi_dgram_type SPI_DGRAM;
    logic [7:0] RX_BYTE, TX_BYTE, c;
    logic TX_VALID, DRIVER_ONE_STEPDIR_ENABLE, DRIVER_TWO_STEPDIR_ENABLE, CLK_SOURCE_EXT;
    logic CHOPPER_ONE_RUN, CHOPPER_TWO_RUN, SHORT_GUARD_ACTIVE;
    logic [31:0] GLOBAL_CONFIG_REG, GLOBAL_STATUS_REG, CHOPPER_CONFIG_REG_ONE, CHOPPER_CONFIG_REG_TWO;
    logic [31:0] CURRENT_REG_ONE, CURRENT_REG_TWO;
    logic [7:0] exp_reply [0:7];
    int miscompares = 0;
    int checks_done = 0;
    always #4 REF_CLK = ~REF_CLK;
    stepper_cfg_top stepper_cfg_top_i (.REF_CLK, .RESETN, .CLK_EN, .SPI_VALID, .SPI_DGRAM, .RX_VALID, .RX_BYTE,
        .TX_READY, .UART_ADDRESS_SELECT_PIN, .CLK_PIN, .SHORT_GUARD_EN, .TX_VALID, .TX_BYTE, .GLOBAL_CONFIG_REG,
        .GLOBAL_STATUS_REG, .CHOPPER_CONFIG_REG_ONE, .CHOPPER_CONFIG_REG_TWO, .CURRENT_REG_ONE, .CURRENT_REG_TWO,
        .DRIVER_ONE_STEPDIR_ENABLE, .DRIVER_TWO_STEPDIR_ENABLE, .CLK_SOURCE_EXT, .CHOPPER_ONE_RUN,
        .CHOPPER_TWO_RUN, .SHORT_GUARD_ACTIVE);
    host_link_model host_link_model_i (.clk(REF_CLK), .tx_valid(TX_VALID), .tx_byte(TX_BYTE),
        .spi_valid(SPI_VALID), .spi_dgram(SPI_DGRAM), .rx_valid(RX_VALID), .rx_byte(RX_BYTE),
        .tx_ready(TX_READY));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic clk_wait(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic summarize;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk_wait(5000);
        miscompares++;
        summarize();
    end
    initial begin
        REF_CLK = 1'b0;
        RESETN = 1'b0;
        CLK_EN = 1'b1;
        UART_ADDRESS_SELECT_PIN = 1'b0;
        CLK_PIN = 1'b0;
        SHORT_GUARD_EN = 1'b0;
        clk_wait(12);
        RESETN = 1'b1;
        check(GLOBAL_STATUS_REG, 32'h0000_0001, "status after reset");
        check(GLOBAL_CONFIG_REG | CHOPPER_CONFIG_REG_ONE | CHOPPER_CONFIG_REG_TWO | CURRENT_REG_ONE
              | CURRENT_REG_TWO, 32'h0000_0000, "config after reset");
        check({25'h0, TX_VALID, DRIVER_ONE_STEPDIR_ENABLE, DRIVER_TWO_STEPDIR_ENABLE, CLK_SOURCE_EXT,
               CHOPPER_ONE_RUN, CHOPPER_TWO_RUN, SHORT_GUARD_ACTIVE}, 32'h0000_0000, "flags after reset");
        host_link_model_i.spi_send(40'h80_0000_0006, 1'b0);
        host_link_model_i.spi_send(40'hEC_0001_00C3, 1'b0);
        host_link_model_i.spi_send(40'h00_0000_00FF, 1'b0);
        host_link_model_i.spi_send(40'hB0_0006_1F05, 1'b1);
        check(GLOBAL_CONFIG_REG, 32'h0000_0006, "spi global config");
        check({30'h0, DRIVER_ONE_STEPDIR_ENABLE, DRIVER_TWO_STEPDIR_ENABLE}, 32'h0000_0003, "stepdir");
        check(CHOPPER_CONFIG_REG_ONE, 32'h0001_00C3, "spi chopper one");
        check(CURRENT_REG_ONE, 32'h0006_1F05, "spi current one");
        host_link_model_i.uart_write(8'h00, 8'hEC, 32'h0001_00C5, 1'b0);
        host_link_model_i.uart_write(8'h00, 8'hB0, 32'h0001_1405, 1'b0);
        host_link_model_i.uart_write(8'h00, 8'hFC, 32'h0001_00C5, 1'b0);
        host_link_model_i.uart_write(8'h00, 8'hD0, 32'h0001_1405, 1'b0);
        host_link_model_i.uart_write(8'h00, 8'h80, 32'h0000_0000, 1'b1);
        host_link_model_i.uart_write(8'h01, 8'h80, 32'h0000_0000, 1'b0);
        clk_wait(1);
        check(CHOPPER_CONFIG_REG_ONE, 32'h0001_00C5, "uart chopper one");
        check(CHOPPER_CONFIG_REG_TWO, 32'h0001_00C5, "uart chopper two");
        check(CURRENT_REG_ONE, 32'h0001_1405, "uart current one");
        check(CURRENT_REG_TWO, 32'h0001_1405, "uart current two");
        check(GLOBAL_CONFIG_REG, 32'h0000_0006, "bad frames ignored");
        UART_ADDRESS_SELECT_PIN = 1'b1;
        host_link_model_i.uart_write(8'h01, 8'h80, 32'h0000_0004, 1'b0);
        clk_wait(1);
        check({30'h0, DRIVER_ONE_STEPDIR_ENABLE, DRIVER_TWO_STEPDIR_ENABLE}, 32'h0000_0001, "address one");
        UART_ADDRESS_SELECT_PIN = 1'b0;
        host_link_model_i.uart_write(8'h00, 8'h80, 32'h0000_0006, 1'b0);
        c = host_link_model_i.crc_step(host_link_model_i.crc_step(host_link_model_i.crc_step(8'h00, 8'h05),
            8'h00), 8'h01);
        check({24'h0, c}, 32'h0000_00C1, "request check byte");
        exp_reply = '{8'h05, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        c = 8'h00;
        for (int i = 0; i < 7; i++) begin
            c = host_link_model_i.crc_step(c, exp_reply[i]);
        end
        exp_reply[7] = c;
        host_link_model_i.uart_read(8'h00, 8'h01);
        for (int i = 0; i < 8; i++) begin
            check({24'h0, host_link_model_i.reply[i]}, {24'h0, exp_reply[i]}, "status reply byte");
        end
        check({31'h0, TX_VALID}, 32'h0000_0000, "reply ended");
        check(GLOBAL_CONFIG_REG, 32'h0000_0006, "uart address zero");
        host_link_model_i.spi_send(40'h81_0000_0001, 1'b1);
        check(GLOBAL_STATUS_REG, 32'h0000_0000, "status cleared");
        CLK_EN = 1'b0;
        host_link_model_i.spi_send(40'h80_0000_0002, 1'b1);
        check(GLOBAL_CONFIG_REG, 32'h0000_0006, "frozen without clock enable");
        CLK_EN = 1'b1;
        SHORT_GUARD_EN = 1'b1;
        check({29'h0, CLK_SOURCE_EXT, CHOPPER_ONE_RUN, CHOPPER_TWO_RUN}, 32'h0000_0003, "internal osc");
        host_link_model_i.spi_send(40'h80_0000_0000, 1'b1);
        check({30'h0, DRIVER_ONE_STEPDIR_ENABLE, DRIVER_TWO_STEPDIR_ENABLE}, 32'h0000_0000, "drivers off");
        CLK_PIN = 1'b1;
        clk_wait(1);
        check({31'h0, CLK_SOURCE_EXT}, 32'h0000_0001, "external selected");
        // Pin toggles every 4 cycles, about 15.6 MHz
        for (int i = 0; i < 6; i++) begin
            clk_wait(4);
            CLK_PIN = ~CLK_PIN;
        end
        clk_wait(120);
        check({29'h0, CLK_SOURCE_EXT, CHOPPER_ONE_RUN, CHOPPER_TWO_RUN}, 32'h0000_0007, "clock running");
        clk_wait(10);
        check({29'h0, CHOPPER_ONE_RUN, CHOPPER_TWO_RUN, SHORT_GUARD_ACTIVE}, 32'h0000_0001, "clock stopped");
        SHORT_GUARD_EN = 1'b0;
        clk_wait(1);
        check({31'h0, SHORT_GUARD_ACTIVE}, 32'h0000_0000, "guard off without clock");
        CLK_PIN = ~CLK_PIN;
        clk_wait(3);
        check({29'h0, CLK_SOURCE_EXT, CHOPPER_ONE_RUN, CHOPPER_TWO_RUN}, 32'h0000_0007, "clock resumed");
        summarize();
    end
endmodule
`default_nettype wire
